// >>> logic/gt16_pkg.sv
`default_nettype none
package gt16_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] GT16_OFS_CONTROL   = 8'h00;
  localparam logic [7:0] GT16_OFS_GATE_CTRL = 8'h04;
  localparam logic [7:0] GT16_OFS_CNT_LOW   = 8'h08;
  localparam logic [7:0] GT16_OFS_CNT_HIGH  = 8'h0C;
  localparam logic [7:0] GT16_OFS_CC_LOW    = 8'h10;
  localparam logic [7:0] GT16_OFS_CC_HIGH   = 8'h14;
  localparam logic [7:0] GT16_OFS_CC_MODE   = 8'h18;
  localparam logic [7:0] GT16_OFS_FLAGS     = 8'h1C;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int GT16_CTL_CS_LSB   = 6;
  localparam int GT16_CTL_PS_LSB   = 4;
  localparam int GT16_CTL_OSC_EN   = 3;
  localparam int GT16_CTL_SYNC_DIS = 2;
  localparam int GT16_CTL_ON       = 0;
  localparam logic [7:0] GT16_CTL_WMASK = 8'hFD;
  // ----------------------------------------------------------------
  // gate control fields
  // ----------------------------------------------------------------
  localparam int GT16_GC_EN     = 7;
  localparam int GT16_GC_POL    = 6;
  localparam int GT16_GC_TOGGLE = 5;
  localparam int GT16_GC_SPM    = 4;
  localparam int GT16_GC_GO     = 3;
  localparam int GT16_GC_VAL    = 2;
  localparam int GT16_GC_SS_LSB = 0;
  // ----------------------------------------------------------------
  // flag bits and reset values
  // ----------------------------------------------------------------
  localparam int GT16_FLG_OVF  = 0;
  localparam int GT16_FLG_GATE = 1;
  localparam int GT16_FLG_CMP  = 2;
  localparam logic [7:0]  GT16_RST_CONTROL   = 8'h00;
  localparam logic [7:0]  GT16_RST_GATE_CTRL = 8'h00;
  localparam logic [15:0] GT16_RST_COUNT     = 16'h0000;
  localparam logic [15:0] GT16_CNT_MAX       = 16'hFFFF;
  // ----------------------------------------------------------------
  // clock source, prescale, gate source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] GT16_CS_FOSC4   = 2'h0;
  localparam logic [1:0] GT16_CS_FOSC    = 2'h1;
  localparam logic [1:0] GT16_CS_PIN     = 2'h2;
  localparam logic [1:0] GT16_CS_CAPSENS = 2'h3;
  localparam logic [1:0] GT16_GS_PIN     = 2'h0;
  localparam logic [1:0] GT16_GS_OVF8    = 2'h1;
  localparam logic [1:0] GT16_GS_CMP1    = 2'h2;
  localparam logic [1:0] GT16_GS_CMP2    = 2'h3;
  localparam logic [1:0] GT16_INSTR_DIV  = 2'h3;
  typedef enum logic [1:0] {GT16_CC_OFF, GT16_CC_CAPTURE, GT16_CC_COMPARE, GT16_CC_SPECIAL}
    gt16_ccmode_t;
endpackage
`default_nettype wire

// >>> logic/gt16_clksrc.sv
`timescale 1ns/100ps
`default_nettype none
module gt16_clksrc
  import gt16_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // selection
  input  wire logic [1:0] clock_source_select,
  input  wire logic       osc_enable,
  input  wire logic       sync_disable,
  // raw sources
  input  wire logic       ext_clock_pin,
  input  wire logic       crystal_pins,
  input  wire logic       cap_sense_oscillator,
  // one-cycle count pulse
  output logic            tick
);
  logic [1:0] div_q;
  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic       raw;
  logic       chosen;

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    raw = (clock_source_select == GT16_CS_CAPSENS) ? cap_sense_oscillator :
          (osc_enable ? crystal_pins : ext_clock_pin);
    chosen = sync_disable ? raw : sync2_q;
    case (clock_source_select)
      GT16_CS_FOSC4: tick = (div_q == GT16_INSTR_DIV);
      GT16_CS_FOSC:  tick = 1'b1;
      default:       tick = chosen & ~prev_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end

  // prev starts high so a low level must be seen before the first count edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b1;
    end
    else
    begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      prev_q  <= chosen;
    end
  end
endmodule
`default_nettype wire

// >>> logic/gt16_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module gt16_prescale
  import gt16_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [1:0] prescale_select,
  // pulses
  input  wire logic       tick_in,
  output logic            tick_out
);
  logic [2:0] cnt_q;
  logic [2:0] last;

  always_comb
  begin
    last     = 3'((4'h1 << prescale_select) - 4'h1);
    tick_out = run & tick_in & (cnt_q >= last);
  end

  // stopping the timer restarts the division
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 3'h0;
    else if (!run)
      cnt_q <= 3'h0;
    else if (tick_in)
      cnt_q <= (cnt_q >= last) ? 3'h0 : cnt_q + 3'h1;
  end

  AST_PRESC_DIV1: assert property (@(posedge pclk) disable iff (!presetn)
    run && tick_in && prescale_select == 2'h0 |-> tick_out)
    else $error("prescale 1:1 dropped a pulse");
endmodule
`default_nettype wire

// >>> logic/gt16_top.sv
// Summary of operation
// - capture event copies the counter into the capture/compare pair
// - compare mode flags a match when compare pair equals the counter
// - special event trigger clears the counter; compare pair acts as period
// - a special event clear never sets the overflow flag
// - a counter byte write in the same cycle beats the special event clear
// - clock source: 11 cap-sense, 10 pin or crystal, 01 system, 00 system/4
// - source 10 uses crystal when oscillator enabled, else pin rising edges
// - prescaler divides by 8, 4, 2 or 1 for codes 11 to 00
// - oscillator enable bit switches the low-power oscillator on or off
// - sync-disable 0 synchronises external clock; ignored for internal sources
// - timer-on enables counting; off stops counter and clears toggle flop
// - gate enable makes counting depend on the gate while timer is on
// - gate polarity 1 counts while gate high, 0 while low
// - toggle mode toggles a flop on gate rising edges, else holds it clear
// - single-pulse mode bit hands gate control to pulse acquisition
// - go/done reads 1 while armed; software sets it, hardware clears it
// - read-only gate value shows the gate state regardless of gate enable
// - gate source: pin, 8-bit overflow, comparator one, comparator two
// - writable control bits reset to zero on power-on and brown-out reset only
// - counter wraps from maximum to zero and sets the overflow flag
// - falling gate value sets the gate event flag even with gate disabled
// - single pulse counts from next gate edge, clears go/done on trailing edge
// - with gating enabled the counter holds while the gate is inactive
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module gt16_top
  import gt16_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // counter clock sources
  input  wire logic        ext_clock_pin,
  input  wire logic        crystal_pins,
  input  wire logic        cap_sense_oscillator,
  // gate sources
  input  wire logic        gate_pin,
  input  wire logic        overflow8_pulse,
  input  wire logic        comparator_one_sync_out,
  input  wire logic        comparator_two_sync_out,
  // capture/compare unit
  input  wire logic        capture_event,
  output logic             compare_match,
  // status and oscillator control
  output logic             osc_enable,
  output logic             overflow_flag,
  output logic             gate_event_flag
);
  logic [7:0]   control_q;
  logic [7:0]   gate_ctrl_q;
  logic [15:0]  count_q;
  logic [15:0]  capcmp_q;
  gt16_ccmode_t ccmode_q;
  logic [2:0]   flags_q;
  logic         tff_q;
  logic         gsrc_prev_q;
  logic         gact_prev_q;
  logic         sp_run_q;
  logic         gate_value_q;
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         cmp_q;
  logic         src_tick;
  logic         inc_tick;
  logic         gsrc;
  logic         gsig;
  logic         gact;
  logic         gval;
  logic         count_en;
  logic         wr;
  logic         wr_lo;
  logic         wr_hi;
  logic         sev;
  logic         timer_on;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // apb decode: answer in the first access cycle, no wait states
  // ----------------------------------------------------------------
  assign wr    = psel & penable & pready_q & pwrite;
  assign wr_lo = wr & hit(paddr, GT16_OFS_CNT_LOW);
  assign wr_hi = wr & hit(paddr, GT16_OFS_CNT_HIGH);
  assign timer_on = control_q[GT16_CTL_ON];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel & ~penable;
      pslverr_q <= 1'b0;
      if (psel && !penable)
      begin
        prdata_q <= 32'h0000_0000;
        case (paddr)
          GT16_OFS_CONTROL:   prdata_q[7:0] <= control_q;
          GT16_OFS_GATE_CTRL: prdata_q[7:0] <= {gate_ctrl_q[7:3], gate_value_q,
                                                gate_ctrl_q[1:0]};
          GT16_OFS_CNT_LOW:   prdata_q[7:0] <= count_q[7:0];
          GT16_OFS_CNT_HIGH:  prdata_q[7:0] <= count_q[15:8];
          GT16_OFS_CC_LOW:    prdata_q[7:0] <= capcmp_q[7:0];
          GT16_OFS_CC_HIGH:   prdata_q[7:0] <= capcmp_q[15:8];
          GT16_OFS_CC_MODE:   prdata_q[1:0] <= ccmode_q;
          GT16_OFS_FLAGS:     prdata_q[2:0] <= flags_q;
          default:            pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // presetn stands for power-on and brown-out; no other reset reaches these
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      control_q <= GT16_RST_CONTROL;
    else if (wr && hit(paddr, GT16_OFS_CONTROL))
      control_q <= pwdata[7:0] & GT16_CTL_WMASK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_ctrl_q <= GT16_RST_GATE_CTRL;
    else if (wr && hit(paddr, GT16_OFS_GATE_CTRL))
    begin
      gate_ctrl_q <= pwdata[7:0];
      gate_ctrl_q[GT16_GC_VAL] <= 1'b0;
    end
    else if (sp_run_q && !gact)
      gate_ctrl_q[GT16_GC_GO] <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccmode_q <= GT16_CC_OFF;
    else if (wr && hit(paddr, GT16_OFS_CC_MODE))
      ccmode_q <= gt16_ccmode_t'(pwdata[1:0]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_enable <= 1'b0;
    else
      osc_enable <= control_q[GT16_CTL_OSC_EN];
  end

  // ----------------------------------------------------------------
  // counter clock and prescaler
  // ----------------------------------------------------------------
  gt16_clksrc u_clksrc (
    .pclk                 (pclk),
    .presetn              (presetn),
    .clock_source_select  (control_q[GT16_CTL_CS_LSB +: 2]),
    .osc_enable           (control_q[GT16_CTL_OSC_EN]),
    .sync_disable         (control_q[GT16_CTL_SYNC_DIS]),
    .ext_clock_pin        (ext_clock_pin),
    .crystal_pins         (crystal_pins),
    .cap_sense_oscillator (cap_sense_oscillator),
    .tick                 (src_tick)
  );

  gt16_prescale u_prescale (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (timer_on),
    .prescale_select (control_q[GT16_CTL_PS_LSB +: 2]),
    .tick_in         (src_tick),
    .tick_out        (inc_tick)
  );

  // ----------------------------------------------------------------
  // gate unit
  // ----------------------------------------------------------------
  always_comb
  begin
    case (gate_ctrl_q[GT16_GC_SS_LSB +: 2])
      GT16_GS_PIN:  gsrc = gate_pin;
      GT16_GS_OVF8: gsrc = overflow8_pulse;
      GT16_GS_CMP1: gsrc = comparator_one_sync_out;
      default:      gsrc = comparator_two_sync_out;
    endcase
    gsig = gate_ctrl_q[GT16_GC_TOGGLE] ? tff_q : gsrc;
    gact = gate_ctrl_q[GT16_GC_POL] ? gsig : ~gsig;
    gval = gate_ctrl_q[GT16_GC_SPM] ? (sp_run_q & gact) : gact;
  end

  // toggle and polarity changed together may misbehave; software avoids it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tff_q <= 1'b0;
    else if (!timer_on || !gate_ctrl_q[GT16_GC_TOGGLE])
      tff_q <= 1'b0;
    else if (gsrc && !gsrc_prev_q)
      tff_q <= ~tff_q;
  end

  // single pulse: arm on go/done, run from next active edge to trailing edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sp_run_q <= 1'b0;
    else if (!gate_ctrl_q[GT16_GC_SPM] || !gact)
      sp_run_q <= 1'b0;
    else if (gate_ctrl_q[GT16_GC_GO] && !gact_prev_q)
      sp_run_q <= 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gsrc_prev_q  <= 1'b0;
      gact_prev_q  <= 1'b1;
      gate_value_q <= 1'b0;
    end
    else
    begin
      gsrc_prev_q  <= gsrc;
      gact_prev_q  <= gact;
      gate_value_q <= gval;
    end
  end

  assign count_en = timer_on & (~gate_ctrl_q[GT16_GC_EN] | gate_value_q);

  // ----------------------------------------------------------------
  // counter and capture/compare
  // ----------------------------------------------------------------
  assign sev = (ccmode_q == GT16_CC_SPECIAL) & (capcmp_q == count_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= GT16_RST_COUNT;
    else if (wr_lo)
      count_q[7:0] <= pwdata[7:0];
    else if (wr_hi)
      count_q[15:8] <= pwdata[7:0];
    else if (sev)
      count_q <= GT16_RST_COUNT;
    else if (inc_tick && count_en)
      count_q <= count_q + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capcmp_q <= GT16_RST_COUNT;
    else if (wr && hit(paddr, GT16_OFS_CC_LOW))
      capcmp_q[7:0] <= pwdata[7:0];
    else if (wr && hit(paddr, GT16_OFS_CC_HIGH))
      capcmp_q[15:8] <= pwdata[7:0];
    else if (capture_event && ccmode_q == GT16_CC_CAPTURE)
      capcmp_q <= count_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmp_q <= 1'b0;
    else
      cmp_q <= ccmode_q[1] & (capcmp_q == count_q);
  end

  // ----------------------------------------------------------------
  // sticky flags: write one to clear, a new event wins over the clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= 3'h0;
    else
    begin
      if (wr && hit(paddr, GT16_OFS_FLAGS))
        flags_q <= flags_q & ~pwdata[2:0];
      if (inc_tick && count_en && count_q == GT16_CNT_MAX && !wr_lo && !wr_hi && !sev)
        flags_q[GT16_FLG_OVF] <= 1'b1;
      if (gate_value_q && !gval)
        flags_q[GT16_FLG_GATE] <= 1'b1;
      if (ccmode_q[1] && capcmp_q == count_q)
        flags_q[GT16_FLG_CMP] <= 1'b1;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign compare_match   = cmp_q;
  assign overflow_flag   = flags_q[GT16_FLG_OVF];
  assign gate_event_flag = flags_q[GT16_FLG_GATE];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WRAP_SETS_OVF: assert property (
    inc_tick && count_en && count_q == GT16_CNT_MAX && !wr && !sev
    |=> count_q == 16'h0000 && overflow_flag)
    else $error("wrap without overflow flag");
  AST_SEV_CLEARS: assert property (sev && !wr_lo && !wr_hi |=> count_q == 16'h0000)
    else $error("special event did not clear counter");
  AST_SEV_NO_OVF: assert property (
    sev && !wr && !overflow_flag |=> !overflow_flag)
    else $error("special event set overflow flag");
  AST_WRITE_WINS: assert property (
    sev && wr_lo |=> count_q[7:0] == $past(pwdata[7:0]))
    else $error("special event beat a counter write");
  AST_CAPTURE: assert property (
    capture_event && ccmode_q == GT16_CC_CAPTURE && !wr |=> capcmp_q == $past(count_q))
    else $error("capture lost the counter value");
  AST_COMPARE: assert property (
    ccmode_q == GT16_CC_COMPARE && capcmp_q == count_q |=> compare_match)
    else $error("compare match not raised");
  AST_OFF_HOLDS: assert property (
    !timer_on && !wr && !sev |=> $stable(count_q) && !tff_q)
    else $error("stopped timer changed");
  AST_GATE_HOLDS: assert property (
    timer_on && gate_ctrl_q[GT16_GC_EN] && !gate_value_q && !wr && !sev |=> $stable(count_q))
    else $error("counter moved with gate closed");
  AST_TFF_CLEAR: assert property (!gate_ctrl_q[GT16_GC_TOGGLE] |=> !tff_q)
    else $error("toggle flop not held clear");
  AST_GATE_EVENT: assert property ($fell(gate_value_q) |-> gate_event_flag)
    else $error("gate event flag missed");
  AST_GO_CLEARS: assert property (
    sp_run_q && !gact && !wr |=> !gate_ctrl_q[GT16_GC_GO] ##1 !sp_run_q)
    else $error("go/done not cleared at pulse end");

  COV_WRAP: cover property (flags_q[GT16_FLG_OVF] && !$past(flags_q[GT16_FLG_OVF]));
  COV_SEV: cover property (sev ##1 count_q == 16'h0000);
  COV_SINGLE_PULSE: cover property ($rose(sp_run_q) ##[1:200] $fell(gate_ctrl_q[GT16_GC_GO]));
  COV_CAPTURE: cover property (capture_event && ccmode_q == GT16_CC_CAPTURE);
endmodule
`default_nettype wire

// >>> sim/gt16_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module gt16_far_model
  import gt16_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench requests
  input  wire logic [3:0] lvl,
  input  wire logic       cap_req,
  // gate sources and capture event
  output logic            gate_pin,
  output logic            overflow8_pulse,
  output logic            comparator_one_sync_out,
  output logic            comparator_two_sync_out,
  output logic            capture_event
);
  logic [7:0] cnt_q;
  logic       req_q;
  // ------------------------------------------------------------
  // 8-bit timer, comparators, capture unit
  // ------------------------------------------------------------
  // overflow is a one-cycle pulse, so it cannot serve as a steady gate level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 8'h00;
      req_q <= 1'b0;
      gate_pin <= 1'b0;
      overflow8_pulse <= 1'b0;
      comparator_one_sync_out <= 1'b0;
      comparator_two_sync_out <= 1'b0;
      capture_event <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
      req_q <= cap_req;
      gate_pin <= lvl[0];
      overflow8_pulse <= lvl[1] && (cnt_q == 8'hFF);
      comparator_one_sync_out <= lvl[2];
      comparator_two_sync_out <= lvl[3];
      capture_event <= cap_req && !req_q;
    end
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench import gt16_pkg::*;;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        cap_req = 1'b0, se, seen = 1'b0;
  logic [2:0]  pc = 3'h0;
  logic [7:0]  paddr = 8'h00;
  logic [3:0]  lvl = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, a;
  logic        pready, pslverr, gate_pin, overflow8_pulse, capture_event, compare_match;
  logic        comparator_one_sync_out, comparator_two_sync_out;
  logic        osc_enable, overflow_flag, gate_event_flag;
  int          fail_count = 0, compares = 0;

  always #5 pclk = ~pclk;
  // free-running counter clocks: pin 1/2, crystal 1/4, cap-sense 1/8 of pclk
  always @(posedge pclk) pc <= pc + 3'h1;

  gt16_top gt16_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_clock_pin(pc[0]), .crystal_pins(pc[1]),
    .cap_sense_oscillator(pc[2]),
    .gate_pin, .overflow8_pulse, .comparator_one_sync_out, .comparator_two_sync_out,
    .capture_event, .compare_match, .osc_enable, .overflow_flag, .gate_event_flag);
  gt16_far_model gt16_far_model_inst (.pclk, .presetn, .lvl, .cap_req, .gate_pin,
    .overflow8_pulse, .comparator_one_sync_out, .comparator_two_sync_out, .capture_event);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // one idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic flag(input logic g, input logic e);
    cmp({31'h0, g}, {31'h0, e});
  endtask
  // low-byte reads 64 cycles apart; settle first so gate latency is out of it
  task automatic meas(input logic [7:0] e);
    repeat (8) @(posedge pclk);
    apb(1'b0, GT16_OFS_CNT_LOW, 8'h00);
    a = r;
    repeat (61) @(posedge pclk);
    apb(1'b0, GT16_OFS_CNT_LOW, 8'h00);
    cmp((r - a) & 32'hFF, {24'h0, e});
  endtask
  task automatic end_sim;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    end_sim;
  end
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, GT16_OFS_CONTROL, 8'h00);
    cmp(r, 32'h0);
    apb(1'b0, GT16_OFS_GATE_CTRL, 8'h00);
    cmp(r & 32'hFB, 32'h0);
    apb(1'b0, 8'h20, 8'h00);
    flag(se, 1'b1);
    apb(1'b1, GT16_OFS_CONTROL, 8'hFE);
    apb(1'b0, GT16_OFS_CONTROL, 8'h00);
    cmp(r, 32'hFC);
    flag(osc_enable, 1'b1);
    for (int c = 0; c < 4; c++)
      for (int p = 0; p < 4; p++)
      begin
        apb(1'b1, GT16_OFS_CONTROL, {c[1:0], p[1:0], 4'h1});
        meas(8'((c == 0 ? 16 : c == 1 ? 64 : c == 2 ? 32 : 8) >> p));
      end
    apb(1'b1, GT16_OFS_CONTROL, 8'hAD);
    meas(8'h04);
    apb(1'b1, GT16_OFS_CONTROL, 8'h00);
    apb(1'b1, GT16_OFS_CNT_HIGH, 8'hFF);
    apb(1'b1, GT16_OFS_CNT_LOW, 8'hF0);
    apb(1'b1, GT16_OFS_CONTROL, 8'h41);
    repeat (30) @(posedge pclk);
    apb(1'b0, GT16_OFS_CNT_HIGH, 8'h00);
    cmp(r, 32'h0);
    flag(overflow_flag, 1'b1);
    apb(1'b1, GT16_OFS_FLAGS, 8'h07);
    flag(overflow_flag, 1'b0);
    apb(1'b1, GT16_OFS_GATE_CTRL, 8'hC0);
    meas(8'h00);
    apb(1'b1, GT16_OFS_GATE_CTRL, 8'h80);
    meas(8'h40);
    for (int s = 0; s < 4; s++)
      if (s != 1)
      begin
        lvl <= 4'(1 << s);
        apb(1'b1, GT16_OFS_GATE_CTRL, 8'hC0 | 8'(s));
        meas(8'h40);
      end
    lvl <= 4'hD;
    apb(1'b1, GT16_OFS_GATE_CTRL, 8'h81);
    meas(8'h40);
    lvl <= 4'h1;
    apb(1'b1, GT16_OFS_GATE_CTRL, 8'h40);
    apb(1'b0, GT16_OFS_GATE_CTRL, 8'h00);
    cmp(r & 32'h04, 32'h04);
    apb(1'b1, GT16_OFS_FLAGS, 8'h07);
    lvl <= 4'h0;
    repeat (8) @(posedge pclk);
    flag(gate_event_flag, 1'b1);
    apb(1'b1, GT16_OFS_GATE_CTRL, 8'hD8);
    apb(1'b0, GT16_OFS_GATE_CTRL, 8'h00);
    cmp(r & 32'h08, 32'h08);
    lvl <= 4'h1;
    repeat (8) @(posedge pclk);
    lvl <= 4'h0;
    repeat (8) @(posedge pclk);
    apb(1'b0, GT16_OFS_GATE_CTRL, 8'h00);
    cmp(r & 32'h08, 32'h00);
    apb(1'b1, GT16_OFS_CONTROL, 8'h00);
    apb(1'b1, GT16_OFS_CNT_LOW, 8'h5A);
    apb(1'b1, GT16_OFS_CC_MODE, 8'h01);
    cap_req <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, GT16_OFS_CC_LOW, 8'h00);
    cmp(r, 32'h5A);
    apb(1'b1, GT16_OFS_CNT_HIGH, 8'h00);
    apb(1'b1, GT16_OFS_CNT_LOW, 8'h00);
    apb(1'b1, GT16_OFS_CC_HIGH, 8'h00);
    apb(1'b1, GT16_OFS_CC_LOW, 8'h10);
    apb(1'b1, GT16_OFS_CC_MODE, 8'h03);
    apb(1'b1, GT16_OFS_GATE_CTRL, 8'h00);
    apb(1'b1, GT16_OFS_FLAGS, 8'h07);
    apb(1'b1, GT16_OFS_CONTROL, 8'h01);
    repeat (200) @(posedge pclk) seen = seen | compare_match;
    flag(seen, 1'b1);
    apb(1'b0, GT16_OFS_CNT_LOW, 8'h00);
    flag(r <= 32'h10, 1'b1);
    flag(overflow_flag, 1'b0);
    apb(1'b0, GT16_OFS_FLAGS, 8'h00);
    cmp(r & 32'h04, 32'h04);
    // a counter byte write beats the special event clear while the counter equals a zero period
    apb(1'b1, GT16_OFS_CONTROL, 8'h00);
    apb(1'b1, GT16_OFS_CC_LOW, 8'h00);
    apb(1'b1, GT16_OFS_CNT_LOW, 8'h00);
    apb(1'b1, GT16_OFS_CNT_LOW, 8'h33);
    apb(1'b0, GT16_OFS_CNT_LOW, 8'h00);
    cmp(r, 32'h33);
    end_sim;
  end
endmodule
`default_nettype wire
